// >>> src/ops_fifo.sv
/*
 * Holds no code: the result FIFO module sits beside the sequencer,
 * so that all logic of the block lives in one design file.
 * Assumes the sequencer file and the package are compiled with it.
 */

// >>> src/ops_pkg.sv
/*
 * Shared constants and types for the optical phase sequencer:
 * register offsets, field positions, reset values and state codes.
 * Assumes a 125 MHz clk_sys and a 24-bit register port.
 */
`default_nettype none
package ops_pkg;
	localparam int DATA_W = 24;
	localparam int ADDR_W = 8;
	localparam int CODE_W = 6;
	localparam int GSEL_W = 3;
	localparam int CONV_W = 22;
	localparam int FIFO_DEPTH = 4;
	localparam int NUM_PH = 4;
	// Register offsets
	localparam logic [7:0] ADDR_PERIOD = 8'h1D;
	localparam logic [7:0] ADDR_CTRL = 8'h1E;
	localparam logic [7:0] ADDR_PHLEN = 8'h1F;
	localparam logic [7:0] ADDR_GAIN = 8'h21;
	localparam logic [7:0] ADDR_LED = 8'h22;
	localparam logic [7:0] ADDR_SMP0 = 8'h2A;
	localparam logic [7:0] ADDR_STATUS = 8'h30;
	// Field positions
	localparam int LED1_LSB = 0;
	localparam int LED2_LSB = 6;
	localparam int LED3_LSB = 12;
	localparam int GAIN1_LSB = 0;
	localparam int CF1_LSB = 3;
	localparam int GAIN2_LSB = 6;
	localparam int CF2_LSB = 9;
	localparam int SEPEN_BIT = 15;
	localparam int RUN_BIT = 0;
	localparam int READY_BIT = 0;
	// Reset values
	localparam logic [23:0] PERIOD_RST = 24'h00_0400;
	localparam logic [23:0] PHLEN_RST = 24'h00_0040;
	localparam logic [23:0] LED_RST = 24'h00_0000;
	localparam logic [23:0] GAIN_RST = 24'h00_0000;
	localparam logic [23:0] CTRL_RST = 24'h00_0000;
	// Overrange sample patterns
	localparam logic [2:0] OVER_POS = 3'h1;
	localparam logic [2:0] OVER_NEG = 3'h6;
	typedef enum logic [4:0] {
		ST_E2 = 5'h01,
		ST_E3 = 5'h02,
		ST_E1 = 5'h04,
		ST_AMB = 5'h08,
		ST_REST = 5'h10
	} ops_state_t;
	typedef struct packed {
		logic overPos;
		logic overNeg;
		logic [CONV_W-1:0] code;
	} ops_conv_t;
endpackage
`default_nettype wire

// >>> src/ops_sequencer.sv
/*
 * Four-phase sampling sequencer for an optical pulse front end.
 * Drives emitters, filter switches, converter resets and gain sets,
 * and files converter results into four sample registers.
 * Also holds the small result FIFO that buffers converter words.
 * Assumes converter results arrive on clk_sys in phase order.
 */
// The strobed register port was decided locally.
// Summary of operation
// - Four 24-bit samples per period, each in its own register.
// - Whole sequence repeats once every programmed repetition period.
// - Four phases; each filter switch closes only in its phase.
// - Four per-phase converter resets; combined reset is their OR.
// - Phase order: emitter two, three, one, then ambient.
// - Each emitter is driven only during its own phase.
// - Two gain/capacitance sets, each applied to designated phases.
// - Separate 6-bit current code per emitter, applied independently.
// - Code is unsigned, 63 equal steps from 0 to 100 mA.
// - Emitter-one code lives at offset 22h, zero after reset.
// - 22-bit result sign-extended into 24 bits within full scale.
// - Bits 23:21 read 001 above and 110 below full scale.
// - One gain for all phases unless separate-gain enable is set.
`timescale 1ns/1ps
`default_nettype none
module ops_sequencer
	import ops_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [DATA_W-1:0] regRdata,
	input wire logic convValid,
	input wire ops_conv_t convWord,
	output logic convReady,
	output logic [NUM_PH-1:0] filterConnect,
	output logic [2:0] emitterOn,
	output logic [CODE_W-1:0] emitterOneCurrentCode,
	output logic [CODE_W-1:0] emitterTwoCurrentCode,
	output logic [CODE_W-1:0] emitterThreeCurrentCode,
	output logic [NUM_PH-1:0] convResetPhase,
	output logic convResetCombined,
	output logic [GSEL_W-1:0] receiverGainSelect,
	output logic [GSEL_W-1:0] feedbackCapSelect,
	output logic cyclePowerdownWindow,
	output logic dataReady
);
	// Sign-extend or flag overrange for one converter result
	function automatic logic [DATA_W-1:0] fmtSample(input ops_conv_t w);
		logic [DATA_W-1:0] r;
		r = {{2{w.code[CONV_W-1]}}, w.code};
		if (w.overPos) begin
			r = {OVER_POS, {(DATA_W-3){1'b1}}};
		end else if (w.overNeg) begin
			r = {OVER_NEG, {(DATA_W-3){1'b0}}};
		end
		return r;
	endfunction

	logic [DATA_W-1:0] pulseRepetitionRate;
	logic [DATA_W-1:0] phaseLen;
	logic [DATA_W-1:0] ctrl;
	logic [DATA_W-1:0] gainCfg;
	logic [DATA_W-1:0] emitterOneCurrentSetting;
	logic [DATA_W-1:0] sample [NUM_PH];
	logic readySticky;
	ops_state_t state;
	ops_state_t next_state;
	logic [DATA_W-1:0] periodCnt;
	logic [DATA_W-1:0] phaseCnt;
	logic run;
	logic periodEnd;
	logic phaseEnd;
	logic [1:0] smpIdx;
	logic fifoValid;
	ops_conv_t fifoWord;
	logic pop;
	logic separateGainEnable;
	logic useSecond;

	assign run = ctrl[RUN_BIT];
	assign separateGainEnable = gainCfg[SEPEN_BIT];
	assign periodEnd = periodCnt == pulseRepetitionRate - 24'h00_0001;
	assign phaseEnd = phaseCnt == phaseLen - 24'h00_0001;
	// Draining stalls while stopped, so the FIFO fills and pushes back
	assign pop = fifoValid && run;

	// Converter results are buffered; convReady is the FIFO's flag
	ops_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) resultFifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.inValid(convValid),
		.inData(convWord),
		.inReady(convReady),
		.outValid(fifoValid),
		.outData(fifoWord),
		.outReady(pop)
	);

	// Register writes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pulseRepetitionRate <= PERIOD_RST;
			phaseLen <= PHLEN_RST;
			ctrl <= CTRL_RST;
			gainCfg <= GAIN_RST;
			emitterOneCurrentSetting <= LED_RST;
		end else if (regWr) begin
			if (regAddr == ADDR_PERIOD) begin
				pulseRepetitionRate <= regWdata;
			end else if (regAddr == ADDR_PHLEN) begin
				phaseLen <= regWdata;
			end else if (regAddr == ADDR_CTRL) begin
				ctrl <= regWdata;
			end else if (regAddr == ADDR_GAIN) begin
				gainCfg <= regWdata;
			end else if (regAddr == ADDR_LED) begin
				emitterOneCurrentSetting <= regWdata;
			end
		end
	end

	// Register reads; unmapped offsets answer zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			regRdata <= '0;
		end else if (regRd) begin
			if (regAddr == ADDR_PERIOD) begin
				regRdata <= pulseRepetitionRate;
			end else if (regAddr == ADDR_PHLEN) begin
				regRdata <= phaseLen;
			end else if (regAddr == ADDR_CTRL) begin
				regRdata <= ctrl;
			end else if (regAddr == ADDR_GAIN) begin
				regRdata <= gainCfg;
			end else if (regAddr == ADDR_LED) begin
				regRdata <= emitterOneCurrentSetting;
			end else if (regAddr >= ADDR_SMP0 && regAddr < ADDR_SMP0 + 8'h04) begin
				regRdata <= sample[2'(regAddr - ADDR_SMP0)];
			end else if (regAddr == ADDR_STATUS) begin
				regRdata <= {{(DATA_W-1){1'b0}}, readySticky};
			end else begin
				regRdata <= '0;
			end
		end
	end

	// Phase order within a period
	always_comb begin
		next_state = state;
		case (state)
			ST_E2: if (phaseEnd) next_state = ST_E3;
			ST_E3: if (phaseEnd) next_state = ST_E1;
			ST_E1: if (phaseEnd) next_state = ST_AMB;
			ST_AMB: if (phaseEnd) next_state = ST_REST;
			ST_REST: next_state = ST_REST;
			default: next_state = ST_REST;
		endcase
		if (!run) begin
			next_state = ST_REST;
		end else if (periodEnd) begin
			next_state = ST_E2;
		end
	end

	// Period and phase timing; a period shorter than four phases cuts the tail
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= ST_REST;
			periodCnt <= '0;
			phaseCnt <= '0;
		end else begin
			state <= next_state;
			if (!run || periodEnd) begin
				periodCnt <= '0;
			end else begin
				periodCnt <= periodCnt + 24'h00_0001;
			end
			if (next_state != state) begin
				phaseCnt <= '0;
			end else begin
				phaseCnt <= phaseCnt + 24'h00_0001;
			end
		end
	end

	// Pin-facing phase outputs, one cycle behind the state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			filterConnect <= '0;
			emitterOn <= '0;
			convResetPhase <= '0;
			convResetCombined <= 1'b0;
			cyclePowerdownWindow <= 1'b0;
		end else begin
			filterConnect <= state[NUM_PH-1:0];
			emitterOn <= {state == ST_E3, state == ST_E2, state == ST_E1};
			// Converter reset at the first cycle of each phase
			convResetPhase <= (phaseCnt == '0) ? state[NUM_PH-1:0] : '0;
			convResetCombined <= (phaseCnt == '0) && |state[NUM_PH-1:0];
			cyclePowerdownWindow <= state == ST_REST && run;
		end
	end

	// Gain sets: the second set governs the first two phases when enabled
	assign useSecond = separateGainEnable && (state == ST_E2 || state == ST_E3);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			receiverGainSelect <= '0;
			feedbackCapSelect <= '0;
		end else if (useSecond) begin
			receiverGainSelect <= gainCfg[GAIN2_LSB +: GSEL_W];
			feedbackCapSelect <= gainCfg[CF2_LSB +: GSEL_W];
		end else begin
			receiverGainSelect <= gainCfg[GAIN1_LSB +: GSEL_W];
			feedbackCapSelect <= gainCfg[CF1_LSB +: GSEL_W];
		end
	end

	// Current codes; driver maps code n to n*100/63 mA, about 1.6 mA a step
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			emitterOneCurrentCode <= '0;
			emitterTwoCurrentCode <= '0;
			emitterThreeCurrentCode <= '0;
		end else begin
			emitterOneCurrentCode <= emitterOneCurrentSetting[LED1_LSB +: CODE_W];
			emitterTwoCurrentCode <= emitterOneCurrentSetting[LED2_LSB +: CODE_W];
			emitterThreeCurrentCode <= emitterOneCurrentSetting[LED3_LSB +: CODE_W];
		end
	end

	// File each finished conversion into its phase's register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < NUM_PH; i++) begin
				sample[i] <= '0;
			end
		end else if (pop) begin
			sample[smpIdx] <= fmtSample(fifoWord);
		end
	end

	// Sample slot index; stopping realigns to the first phase
	always_ff @(posedge clk_sys) begin
		if (rst || !run) begin
			smpIdx <= '0;
		end else if (pop) begin
			smpIdx <= smpIdx + 2'h1;
		end
	end

	// Ready pulse and sticky status; a new set wins over a status read
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dataReady <= 1'b0;
			readySticky <= 1'b0;
		end else begin
			dataReady <= pop && smpIdx == 2'h3;
			if (pop && smpIdx == 2'h3) begin
				readySticky <= 1'b1;
			end else if (regRd && regAddr == ADDR_STATUS) begin
				readySticky <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_state_onehot: assert property ($onehot(state))
		else $error("sequencer state not one-hot");
	a_filter_exclusive: assert property ($onehot0(filterConnect))
		else $error("more than one filter connected");
	a_reset_combined: assert property (convResetCombined == (|convResetPhase))
		else $error("combined reset differs from per-phase resets");
	a_emitter_phase: assert property (emitterOn[1] |-> $past(state) == ST_E2)
		else $error("emitter two driven outside its phase");
	a_order_first: assert property ($past(state) == ST_E2 && state != ST_E2 |-> state inside {ST_E3, ST_REST})
		else $error("emitter three does not follow emitter two");
	a_order_next: assert property ($past(state) == ST_E3 && state != ST_E3 |-> state inside {ST_E1, ST_E2, ST_REST})
		else $error("emitter one does not follow emitter three");
	a_period_wrap: assert property (run && periodEnd |=> state == ST_E2 && periodCnt == '0)
		else $error("period did not restart the sequence");
	a_ready_four: assert property (pop && smpIdx == 2'h3 |=> dataReady ##1 !dataReady || pop)
		else $error("data ready missing after fourth sample");
	a_gain_shared: assert property (!separateGainEnable && $stable(gainCfg) |=> receiverGainSelect == $past(gainCfg[GAIN1_LSB +: GSEL_W]))
		else $error("first gain set not applied to all phases");
	a_led_reset: assert property ($fell(rst) |-> emitterOneCurrentSetting == '0)
		else $error("emitter one code not zero after reset");
endmodule

// Small synchronous FIFO, valid/ready on both sides; DEPTH must be a power of two
module ops_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr;
	logic [PW-1:0] rdPtr;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic push;
	logic pop;

	// Handshakes; full and empty come from flops
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outData = mem[rdPtr];
	assign next_count = count + CW'(push) - CW'(pop);

	// Storage needs no reset
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// Pointers and flags
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			inReady <= 1'b0;
			outValid <= 1'b0;
		end else begin
			wrPtr <= wrPtr + PW'(push);
			rdPtr <= rdPtr + PW'(pop);
			count <= next_count;
			inReady <= next_count != CW'(DEPTH);
			outValid <= next_count != '0;
		end
	end
endmodule
`default_nettype wire

// >>> test/ops_conv_model.sv
/*
 * Converter-side partner: one result word per phase start, held until taken.
 * Assumes the sequencer pulses one converter reset at each phase start.
 */
`timescale 1ns/1ps
`default_nettype none
module ops_conv_model
	import ops_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [NUM_PH-1:0] convResetPhase,
	input wire logic convReady,
	input wire logic [7:0] lagCycles,
	input wire logic overMode,
	input wire logic burst,
	output logic convValid,
	output ops_conv_t convWord
);
	int cyc = 0;
	int dueQ[$];
	int phQ[$];
	// Queue a result per phase; lag lets the answer be prompt or slow
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (rst) begin
			convValid <= 1'b0;
			convWord <= '0;
			dueQ.delete();
			phQ.delete();
		end else begin
			for (int i = 0; i < NUM_PH; i++) begin
				if (convResetPhase[i]) begin
					dueQ.push_back(cyc + int'(lagCycles));
					phQ.push_back(i);
				end
			end
			// Five at once fill a four-word buffer and leave one word waiting
			for (int i = 0; i < 5; i++) begin
				if (burst) begin
					dueQ.push_back(cyc);
					phQ.push_back(i);
				end
			end
			if (convValid && convReady) begin
				convValid <= 1'b0;
				convWord <= ~convWord; // Released word must not look valid
			end else if (!convValid && dueQ.size() > 0 && cyc >= dueQ[0]) begin
				convValid <= 1'b1;
				convWord.overPos <= overMode && phQ[0] == 0;
				convWord.overNeg <= overMode && phQ[0] == 1;
				convWord.code <= {2'(phQ[0]), 20'h5_A3C1};
				void'(dueQ.pop_front());
				void'(phQ.pop_front());
			end
		end
	end
endmodule
`default_nettype wire

// >>> test/tb_optical_phase_sequencer.sv
/*
 * Testbench: register accesses and phase monitoring of the sequencer.
 * Assumes the converter model answers each phase with a known word.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_optical_phase_sequencer;
	import ops_pkg::*;
	localparam logic [2:0] EMIT [4] = '{3'b010, 3'b100, 3'b001, 3'b000};
	logic clk_sys = 1'b0;
	logic rst;
	logic [7:0] regAddr;
	logic [23:0] regWdata;
	logic regWr;
	logic regRd;
	logic [23:0] regRdata;
	logic convValid;
	ops_conv_t convWord;
	logic convReady;
	logic [3:0] filterConnect;
	logic [2:0] emitterOn;
	logic [5:0] codeOne;
	logic [5:0] codeTwo;
	logic [5:0] codeThree;
	logic [3:0] convResetPhase;
	logic convResetCombined;
	logic [2:0] gainSel;
	logic [2:0] capSel;
	logic dataReady;
	logic pdWin;
	logic [7:0] lag;
	logic ovr;
	logic burst;
	logic [23:0] v;
	int badCount = 0;
	int cmpCount = 0;
	int cyc = 0;
	int lastE2 = 0;
	int pIdx = 0;
	bit gChk = 0;
	bit sepOn = 0;
	bit pdPrev = 0;

	always #4 clk_sys = ~clk_sys;

	ops_sequencer i_dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .convValid(convValid), .convWord(convWord),
		.convReady(convReady), .filterConnect(filterConnect), .emitterOn(emitterOn),
		.emitterOneCurrentCode(codeOne), .emitterTwoCurrentCode(codeTwo),
		.emitterThreeCurrentCode(codeThree), .convResetPhase(convResetPhase),
		.convResetCombined(convResetCombined), .receiverGainSelect(gainSel), .feedbackCapSelect(capSel),
		.cyclePowerdownWindow(pdWin), .dataReady(dataReady));

	ops_conv_model i_conv (.clk_sys(clk_sys), .rst(rst), .convResetPhase(convResetPhase),
		.convReady(convReady), .lagCycles(lag), .overMode(ovr), .burst(burst), .convValid(convValid),
		.convWord(convWord));

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		cmpCount++;
		if (got !== exp) begin
			badCount++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask

	// Read data stand from the cycle after the strobe until the next read
	task automatic rd(input logic [7:0] a, output logic [23:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(negedge clk_sys);
		d = regRdata;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [23:0] exp);
		logic [23:0] d;
		rd(a, d);
		chk(d, exp);
	endtask

	function automatic logic [23:0] expSmp(input int ph);
		logic [21:0] c;
		c = {2'(ph), 20'h5_A3C1};
		return {{2{c[21]}}, c};
	endfunction

	task automatic waitRdy();
		int n;
		n = 0;
		@(negedge clk_sys);
		while (dataReady !== 1'b1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		chk(24'(dataReady), 24'h00_0001);
	endtask

	task automatic giveVerdict();
		$display("compares %0d mismatches %0d", cmpCount, badCount);
		if (badCount == 0 && cmpCount > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Check each phase start: order, switches, emitters, gain set, spacing
	always @(negedge clk_sys) begin
		cyc++;
		if (!rst) begin
			chk(24'(convResetCombined), 24'(|convResetPhase));
			if (convResetPhase != 4'h0) begin
				chk(24'(convResetPhase), 24'(4'h1 << pIdx));
				chk(24'(filterConnect), 24'(convResetPhase));
				chk(24'(emitterOn), 24'(EMIT[pIdx]));
				chk(24'(pdWin), 24'h00_0000);
				if (gChk) chk(24'({gainSel, capSel}), (sepOn && pIdx < 2) ? 24'h00_0016 : 24'h00_002B);
				if (pIdx == 0 && lastE2 > 0) chk(24'(cyc - lastE2), 24'h00_0040);
				// The rest window must have stood right up to the first phase
				if (pIdx == 0) chk(24'(pdPrev), 24'h00_0001);
				if (pIdx == 0) lastE2 = cyc;
				pIdx = (pIdx + 1) % 4;
			end
		end
		pdPrev = pdWin;
	end

	// Cut a hang short well after the expected run length
	initial begin
		repeat (20000) @(posedge clk_sys);
		badCount++;
		giveVerdict();
	end

	initial begin
		rst = 1'b1;
		regAddr = 8'h00;
		regWdata = 24'h00_0000;
		regWr = 1'b0;
		regRd = 1'b0;
		lag = 8'h03;
		ovr = 1'b0;
		burst = 1'b0;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rdc(ADDR_LED, LED_RST);
		rdc(8'h00, 24'h00_0000);
		wr(ADDR_LED, 24'h01_50BF);
		// Codes follow the register one cycle after the write lands
		repeat (2) @(negedge clk_sys);
		chk(24'({codeThree, codeTwo, codeOne}), 24'h01_50BF);
		rdc(ADDR_LED, 24'h01_50BF);
		wr(ADDR_PERIOD, 24'h00_0040);
		wr(ADDR_PHLEN, 24'h00_0008);
		wr(ADDR_GAIN, 24'h00_0C9D);
		gChk = 1;
		wr(ADDR_CTRL, 24'h00_0001);
		waitRdy();
		for (int i = 0; i < 4; i++) rdc(ADDR_SMP0 + 8'(i), expSmp(i));
		rd(ADDR_STATUS, v);
		chk(24'(v[READY_BIT]), 24'h00_0001);
		rd(ADDR_STATUS, v);
		chk(24'(v[READY_BIT]), 24'h00_0000);
		gChk = 0;
		wr(ADDR_GAIN, 24'h00_8C9D);
		sepOn = 1;
		waitRdy();
		waitRdy();
		gChk = 1;
		lag = 8'h0C;
		ovr = 1'b1;
		waitRdy();
		waitRdy();
		rdc(ADDR_SMP0, 24'h3F_FFFF);
		rdc(ADDR_SMP0 + 8'h01, 24'hC0_0000);
		rdc(ADDR_SMP0 + 8'h02, expSmp(2));
		ovr = 1'b0;
		waitRdy();
		waitRdy();
		wr(ADDR_CTRL, 24'h00_0000);
		lastE2 = 0;
		@(posedge clk_sys);
		burst <= 1'b1;
		@(posedge clk_sys);
		burst <= 1'b0;
		repeat (30) @(negedge clk_sys);
		chk(24'({convValid, convReady}), 24'h00_0002);
		chk(24'(pdWin), 24'h00_0000);
		wr(ADDR_CTRL, 24'h00_0001);
		waitRdy();
		for (int i = 0; i < 4; i++) rdc(ADDR_SMP0 + 8'(i), expSmp(i));
		giveVerdict();
	end
endmodule
`default_nettype wire
